// ---- hw/pmc_ctrl.sv ----
// Purpose: power mode sequencer for run, sleep, deep-sleep and standby
// Assumes: sleep requests from the core are one-cycle pulses
// Notes: lives in the always-on domain; rstn is the power-on reset
// Notes on behaviour
// - Power-on reset restarts the whole core domain.
// - Power-saving mode entered only on a wait instruction or last-handler return after setup.
// - Switchable domain powered everywhere except standby.
// - Flash on after reset; run powerdown bit switches it off in run/run1.
// - Deep-sleep flash powerdown bit turns flash off in deep-sleep.
// - After reset or standby wakeup: run, normal regulator on.
// - Low-power regulator enable selects run1 on the slow oscillator.
// - Sleep on wait with deep select clear; only cpu clock stops.
// - Sleep ends on interrupt, or event, or interrupt as event.
// - Sleep-after-exit waits for return from the last handler.
// - Sleep1 from run1 keeps low-power regulator, returns to run1.
// - Deep-sleep: selector 00, clocks off, fast oscillators off.
// - Deep-sleep exits only on external event line sources.
// - Leaving deep-sleep selects the fast internal oscillator.
// - Pending external line flags cancel deep-sleep entry.
// - Deep-sleep1: selector 01, low-power regulator only.
// - Standby: selector 11, wakeup flag clear, domain powered off.
// - Passing through standby sets the standby flag.
// - Standby left on reset pin, alarm, watchdog, crystal fail, pin edge.
// - Standby exit gives power-on reset and boot from address zero.
// - Standby and deep-sleep1 wakeup wait regulator, flash and oscillator times; deep-sleep skips the regulator, run1 exit the oscillator.
// - Selector 00 deep, 01 deep1, 10 reserved, 11 standby.
// - Standby flag cleared only by power reset or clear bit.
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_ctrl
    import pmc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic core_wfi,
    input wire logic core_wfe,
    input wire logic core_deep_sleep_select,
    input wire logic sleep_after_handler_exit,
    input wire logic pending_irq_as_event,
    input wire logic handler_return_last,
    input wire logic irq_any,
    input wire logic event_any,
    input wire logic ext_irq,
    input wire logic ext_event,
    input wire logic ext_pending,
    input wire logic [1:0] low_power_mode_select,
    input wire logic low_power_regulator_enable,
    input wire logic flash_run_powerdown,
    input wire logic flash_deepsleep_powerdown,
    input wire logic wakeup_flag,
    input wire logic standby_flag_clear,
    input wire pmc_stby_src_type stby_src,
    input wire logic [3:0] wakeup_pin_enable,
    output pmc_mode_type mode,
    output pmc_power_type power,
    output logic standby_flag,
    output logic core_domain_reset_n,
    output logic [31:0] boot_address,
    output logic entry_skipped
);
    // ****************************************
    // Entry decode and wakeup conditions
    // ****************************************
    pmc_mode_type next_mode;
    logic by_wfe;
    logic [3:0] pin_prev;
    logic [`PMC_CNT_W-1:0] wake_cnt;
    logic [`PMC_CNT_W-1:0] next_wake_cnt;
    logic wait_req;
    logic enter_req;
    logic sleep_wake;
    logic deep_wake;
    logic stby_wake;
    logic from_stby;
    logic wake_deep;

    assign wait_req = core_wfi | core_wfe;
    // Sleep-now on wait, or sleep-on-exit after last handler
    assign enter_req = sleep_after_handler_exit ? handler_return_last : wait_req;
    assign sleep_wake = by_wfe ? (event_any | (pending_irq_as_event & irq_any))
                               : irq_any;
    assign deep_wake = by_wfe ? (ext_event | (pending_irq_as_event & ext_irq))
                              : ext_irq;
    assign stby_wake = stby_src.external_reset_pin | stby_src.rtc_alarm
        | stby_src.independent_watchdog | stby_src.low_speed_crystal_fail
        | (|(stby_src.wakeup_pins & ~pin_prev & wakeup_pin_enable));
    assign entry_skipped = enter_req & core_deep_sleep_select & ext_pending
        & (mode == PMC_RUN || mode == PMC_RUN1);

    always_comb begin
        next_mode = mode;
        next_wake_cnt = wake_cnt;
        unique case (mode)
            PMC_RUN, PMC_RUN1: begin
                if (mode == PMC_RUN && low_power_regulator_enable) begin
                    next_mode = PMC_RUN1;
                end else if (mode == PMC_RUN1 && !low_power_regulator_enable) begin
                    next_mode = PMC_WAKE;
                    next_wake_cnt = `PMC_CNT_W'(`PMC_NREG_CYC + `PMC_FLASH_CYC);
                end else if (enter_req && !core_deep_sleep_select) begin
                    next_mode = (mode == PMC_RUN1) ? PMC_SLEEP1 : PMC_SLEEP;
                end else if (enter_req && !ext_pending) begin
                    unique case (low_power_mode_select)
                        `PMC_LPM_DEEP: next_mode = PMC_DEEP;
                        `PMC_LPM_DEEP1: next_mode = PMC_DEEP1;
                        `PMC_LPM_STBY: next_mode = wakeup_flag ? mode : PMC_STBY;
                        default: next_mode = mode;
                    endcase
                end
            end
            PMC_SLEEP: if (sleep_wake) next_mode = PMC_RUN;
            PMC_SLEEP1: if (sleep_wake) next_mode = PMC_RUN1;
            PMC_DEEP, PMC_DEEP1: begin
                if (deep_wake) begin
                    next_mode = PMC_WAKE;
                    next_wake_cnt = (mode == PMC_DEEP1)
                        ? `PMC_CNT_W'(`PMC_OSC_CYC + `PMC_NREG_CYC + `PMC_FLASH_CYC)
                        : `PMC_CNT_W'(`PMC_OSC_CYC + `PMC_FLASH_CYC);
                end
            end
            PMC_STBY: begin
                if (stby_wake) begin
                    next_mode = PMC_WAKE;
                    next_wake_cnt = `PMC_CNT_W'(`PMC_OSC_CYC + `PMC_NREG_CYC + `PMC_FLASH_CYC);
                end
            end
            PMC_WAKE: begin
                if (wake_cnt <= `PMC_CNT_W'(1)) next_mode = PMC_RUN;
                else next_wake_cnt = wake_cnt - `PMC_CNT_W'(1);
            end
            default: next_mode = PMC_RUN;
        endcase
    end

    // ****************************************
    // State registers
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) mode <= PMC_RUN;
        else mode <= next_mode;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) wake_cnt <= '0;
        else wake_cnt <= next_wake_cnt;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) by_wfe <= 1'b0;
        else if (mode != next_mode && (mode == PMC_RUN || mode == PMC_RUN1))
            by_wfe <= core_wfe & ~core_wfi;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) pin_prev <= 4'h0;
        else pin_prev <= stby_src.wakeup_pins;
    end

    // Came from deep sleep or standby, so wakeup ends on fast oscillator
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) wake_deep <= 1'b0;
        else if (mode == PMC_DEEP || mode == PMC_DEEP1 || mode == PMC_STBY) wake_deep <= 1'b1;
        else if (mode == PMC_RUN) wake_deep <= 1'b0;
    end

    // Always-on standby flag, set wins over clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) standby_flag <= 1'b0;
        else if (mode == PMC_STBY) standby_flag <= 1'b1;
        else if (standby_flag_clear) standby_flag <= 1'b0;
    end

    // Wakeup from standby keeps the core domain in reset to the end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) from_stby <= 1'b0;
        else if (mode == PMC_STBY) from_stby <= 1'b1;
        else if (mode == PMC_RUN) from_stby <= 1'b0;
    end

    // ****************************************
    // Power, clock and reset outputs
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        end else begin
            power.normal_core_regulator <= !(next_mode inside
                {PMC_RUN1, PMC_SLEEP1, PMC_DEEP1, PMC_STBY});
            power.low_power_core_regulator <= 1'b1;
            power.fast_internal_oscillator <= !(next_mode inside
                {PMC_DEEP, PMC_DEEP1, PMC_STBY});
            power.high_speed_crystal <= !(next_mode inside {PMC_DEEP, PMC_DEEP1, PMC_STBY});
            power.flash_power <= !(((next_mode == PMC_RUN || next_mode == PMC_RUN1)
                && flash_run_powerdown)
                || ((next_mode == PMC_DEEP || next_mode == PMC_DEEP1)
                && flash_deepsleep_powerdown)
                || next_mode == PMC_STBY);
            power.cpu_clock <= (next_mode == PMC_RUN || next_mode == PMC_RUN1);
            power.run_domain_clocks <= !(next_mode inside
                {PMC_DEEP, PMC_DEEP1, PMC_STBY, PMC_WAKE});
            power.run_domain_power <= (next_mode != PMC_STBY);
            power.sysclk_slow <= (next_mode == PMC_RUN1 || next_mode == PMC_SLEEP1)
                && !(wake_deep && next_mode == PMC_RUN);
        end
    end

    // Core domain held in reset through standby until wakeup completes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) core_domain_reset_n <= 1'b0;
        else core_domain_reset_n <= !(next_mode == PMC_STBY
            || (mode == PMC_STBY) || (next_mode == PMC_WAKE && from_stby));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) boot_address <= `PMC_BOOT_ADDR;
        else boot_address <= `PMC_BOOT_ADDR;
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_wait_sleep;
        (mode == PMC_RUN) && enter_req && !core_deep_sleep_select && !low_power_regulator_enable;
    endsequence
    property p_sleep_entry;
        @(posedge clk) disable iff (!rstn) s_wait_sleep |=> mode == PMC_SLEEP ##1 !power.cpu_clock;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
    property p_no_entry_without_wait;
        @(posedge clk) disable iff (!rstn)
        (mode == PMC_RUN && !enter_req)
            |=> !(mode inside {PMC_SLEEP, PMC_DEEP, PMC_DEEP1, PMC_STBY});
    endproperty
    a_no_entry_without_wait: assert property (p_no_entry_without_wait)
        else $error("mode entered without wait");
    property p_skip;
        @(posedge clk) disable iff (!rstn)
        (mode == PMC_RUN && entry_skipped && !low_power_regulator_enable) |=> mode == PMC_RUN;
    endproperty
    a_skip: assert property (p_skip) else $error("deep entry not skipped");
    property p_stby_power;
        @(posedge clk) disable iff (!rstn) mode == PMC_STBY |-> !power.run_domain_power
            && !power.normal_core_regulator && !core_domain_reset_n;
    endproperty
    a_stby_power: assert property (p_stby_power) else $error("standby power wrong");
    property p_stby_flag;
        @(posedge clk) disable iff (!rstn) mode == PMC_STBY |=> standby_flag;
    endproperty
    a_stby_flag: assert property (p_stby_flag) else $error("standby flag not set");
    property p_flag_hold;
        @(posedge clk) disable iff (!rstn)
        (standby_flag && !standby_flag_clear) |=> standby_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("standby flag lost");
    property p_deep_hold;
        @(posedge clk) disable iff (!rstn) (mode == PMC_DEEP && !deep_wake) |=> mode == PMC_DEEP;
    endproperty
    a_deep_hold: assert property (p_deep_hold) else $error("deep left without source");
    property p_deep_clocks;
        @(posedge clk) disable iff (!rstn) mode inside {PMC_DEEP, PMC_DEEP1}
            |-> !power.fast_internal_oscillator && !power.run_domain_clocks;
    endproperty
    a_deep_clocks: assert property (p_deep_clocks) else $error("deep clocks running");
    property p_wake_time;
        @(posedge clk) disable iff (!rstn) (mode == PMC_DEEP && deep_wake)
            |=> (mode == PMC_WAKE)[*8];
    endproperty
    a_wake_time: assert property (p_wake_time) else $error("wakeup too short");
    sequence s_deep_req;
        (mode == PMC_RUN) && enter_req && core_deep_sleep_select && !ext_pending
            && !low_power_regulator_enable;
    endsequence
    sequence s_wake_last;
        (mode == PMC_WAKE) && (wake_cnt <= `PMC_CNT_W'(1));
    endsequence
    property p_deep_flash;
        @(posedge clk) disable iff (!rstn)
        s_deep_req ##0 (low_power_mode_select == `PMC_LPM_DEEP && flash_deepsleep_powerdown)
            |=> mode == PMC_DEEP && !power.flash_power;
    endproperty
    a_deep_flash: assert property (p_deep_flash) else $error("flash on in deep-sleep");
    property p_reserved_sel;
        @(posedge clk) disable iff (!rstn)
        s_deep_req ##0 (low_power_mode_select == `PMC_LPM_RSVD) |=> mode == PMC_RUN;
    endproperty
    a_reserved_sel: assert property (p_reserved_sel) else $error("reserved entered");
    property p_stby_entry;
        @(posedge clk) disable iff (!rstn)
        s_deep_req ##0 (low_power_mode_select == `PMC_LPM_STBY && !wakeup_flag)
            |=> mode == PMC_STBY;
    endproperty
    a_stby_entry: assert property (p_stby_entry) else $error("standby not entered");
    property p_flash_run_off;
        @(posedge clk) disable iff (!rstn)
        (mode == PMC_RUN && flash_run_powerdown && !enter_req && !low_power_regulator_enable)
            |=> !power.flash_power;
    endproperty
    a_flash_run_off: assert property (p_flash_run_off) else $error("flash on in run");
    property p_sleep_wake;
        @(posedge clk) disable iff (!rstn) mode == PMC_SLEEP && sleep_wake |=> mode == PMC_RUN;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not left");
    property p_sleep1_wake;
        @(posedge clk) disable iff (!rstn) mode == PMC_SLEEP1 && sleep_wake |=> mode == PMC_RUN1;
    endproperty
    a_sleep1_wake: assert property (p_sleep1_wake) else $error("sleep1 not left");
    property p_low_reg;
        @(posedge clk) disable iff (!rstn) mode inside {PMC_RUN1, PMC_SLEEP1, PMC_DEEP1}
            |-> !power.normal_core_regulator && power.low_power_core_regulator;
    endproperty
    a_low_reg: assert property (p_low_reg) else $error("normal regulator on");
    property p_stby_wake;
        @(posedge clk) disable iff (!rstn) mode == PMC_STBY && stby_wake |=> mode == PMC_WAKE;
    endproperty
    a_stby_wake: assert property (p_stby_wake) else $error("standby not left");
    property p_wake_end;
        @(posedge clk) disable iff (!rstn)
        s_wake_last |=> mode == PMC_RUN && power.normal_core_regulator && power.run_domain_power;
    endproperty
    a_wake_end: assert property (p_wake_end) else $error("run not restored");
    property p_fast_after_wake;
        @(posedge clk) disable iff (!rstn)
        s_wake_last |=> power.fast_internal_oscillator && !power.sysclk_slow;
    endproperty
    a_fast_after_wake: assert property (p_fast_after_wake) else $error("slow clock");
    property p_stby_reset;
        @(posedge clk) disable iff (!rstn) mode == PMC_WAKE && from_stby |-> !core_domain_reset_n;
    endproperty
    a_stby_reset: assert property (p_stby_reset) else $error("core reset released early");
endmodule

// ---- hw/pmc_cfg.svh ----
// Purpose: constants for the power mode controller
// Assumes: 100 MHz clk
// Notes: startup times are plain defaults
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define PMC_LPM_DEEP 2'h0
`define PMC_LPM_DEEP1 2'h1
`define PMC_LPM_RSVD 2'h2
`define PMC_LPM_STBY 2'h3
`define PMC_CLK_MHZ 100
`define PMC_NREG_START_NS 2000
`define PMC_FLASH_START_NS 1000
`define PMC_OSC_START_NS 3000
`define PMC_NREG_CYC ((`PMC_NREG_START_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_FLASH_CYC ((`PMC_FLASH_START_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_OSC_CYC ((`PMC_OSC_START_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_BOOT_ADDR 32'h00000000
`define PMC_CNT_W 10
`endif

// ---- hw/pmc_pkg.sv ----
// Purpose: types for the power mode controller
// Assumes: nothing
// Notes: none
package pmc_pkg;
    typedef enum logic [3:0] {
        PMC_RUN = 4'h0,
        PMC_RUN1 = 4'h1,
        PMC_SLEEP = 4'h2,
        PMC_SLEEP1 = 4'h3,
        PMC_DEEP = 4'h4,
        PMC_DEEP1 = 4'h5,
        PMC_STBY = 4'h6,
        PMC_WAKE = 4'h7
    } pmc_mode_type;
    typedef struct packed {
        logic normal_core_regulator;
        logic low_power_core_regulator;
        logic fast_internal_oscillator;
        logic high_speed_crystal;
        logic flash_power;
        logic cpu_clock;
        logic run_domain_clocks;
        logic run_domain_power;
        logic sysclk_slow;
    } pmc_power_type;
    typedef struct packed {
        logic external_reset_pin;
        logic rtc_alarm;
        logic independent_watchdog;
        logic low_speed_crystal_fail;
        logic [3:0] wakeup_pins;
    } pmc_stby_src_type;
endpackage

// ---- bench/pmc_core_model.sv ----
// Purpose: core and wake source model facing the power mode controller
// Assumes: commands arrive from the bench between falling edges
// Notes: every request is a one-cycle pulse; released lines drop to 0
`timescale 1ns/1ps
module pmc_core_model
    import pmc_pkg::*;
(
    input wire logic clk,
    output logic core_wfi,
    output logic core_wfe,
    output logic handler_return_last,
    output logic irq_any,
    output logic event_any,
    output logic ext_irq,
    output logic ext_event,
    output pmc_stby_src_type stby_src
);
    logic [14:0] drv;

    assign {stby_src, core_wfi, core_wfe, handler_return_last} = drv[14:4];
    assign {irq_any, event_any, ext_irq, ext_event} = drv[3:0];

    initial begin
        drv = '0;
    end

    // Wait, handler return and wake sources as one-cycle pulses
    // Wake pins are pulled down, so release means low
    task automatic pulse(input logic [14:0] m);
        @(negedge clk);
        drv <= m;
        @(negedge clk);
        drv <= '0;
    endtask
endmodule

// ---- bench/tb_pmc_ctrl.sv ----
// Purpose: self-checking bench for the power mode controller
// Assumes: startup counts from the shared configuration header
// Notes: every mode change is matched against a queue of expected modes
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module tb_pmc_ctrl
    import pmc_pkg::*;
;
    localparam logic [14:0] WFI = 15'h0040, WFE = 15'h0020, HRL = 15'h0010;
    localparam logic [14:0] IRQ = 15'h0008, EVT = 15'h0004;
    localparam logic [14:0] XIRQ = 15'h0002, XEVT = 15'h0001;
    logic clk = 0, rstn = 0, core_deep_sleep_select = 0, sleep_after_handler_exit = 0;
    logic pending_irq_as_event = 0, ext_pending = 0, low_power_regulator_enable = 0;
    logic flash_run_powerdown = 0, flash_deepsleep_powerdown = 0, wakeup_flag = 0;
    logic standby_flag_clear = 0, standby_flag, core_domain_reset_n, entry_skipped;
    logic core_wfi, core_wfe, handler_return_last, irq_any, event_any, ext_irq, ext_event;
    logic [1:0] low_power_mode_select = 2'h0;
    logic [3:0] wakeup_pin_enable = 4'h0;
    logic [7:0] src;
    logic [31:0] boot_address;
    pmc_stby_src_type stby_src;
    pmc_mode_type mode, last_mode = PMC_RUN;
    pmc_power_type power;
    pmc_mode_type q[$];
    int fail_count = 0, n_checks = 0, wake_cnt = 0, i, p;
    integer seed = 32'h503A;

    always #5 clk = ~clk;

    pmc_core_model pmc_core_model_inst (.clk(clk), .core_wfi(core_wfi), .core_wfe(core_wfe),
        .handler_return_last(handler_return_last), .irq_any(irq_any),
        .event_any(event_any), .ext_irq(ext_irq), .ext_event(ext_event), .stby_src(stby_src));

    pmc_ctrl pmc_ctrl_inst (.clk(clk), .rstn(rstn), .core_wfi(core_wfi), .core_wfe(core_wfe),
        .core_deep_sleep_select(core_deep_sleep_select),
        .sleep_after_handler_exit(sleep_after_handler_exit),
        .pending_irq_as_event(pending_irq_as_event), .handler_return_last(handler_return_last),
        .irq_any(irq_any), .event_any(event_any), .ext_irq(ext_irq), .ext_event(ext_event),
        .ext_pending(ext_pending), .low_power_mode_select(low_power_mode_select),
        .low_power_regulator_enable(low_power_regulator_enable),
        .flash_run_powerdown(flash_run_powerdown),
        .flash_deepsleep_powerdown(flash_deepsleep_powerdown), .wakeup_flag(wakeup_flag),
        .standby_flag_clear(standby_flag_clear), .stby_src(stby_src),
        .wakeup_pin_enable(wakeup_pin_enable), .mode(mode), .power(power),
        .standby_flag(standby_flag), .core_domain_reset_n(core_domain_reset_n),
        .boot_address(boot_address), .entry_skipped(entry_skipped));

    //****************************************
    // Checks
    //****************************************
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (e !== g) begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", name, e, g);
        end
    endtask

    task automatic wait_mode(input pmc_mode_type m);
        int n = 0;
        while (mode !== m && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk("wait_mode", m, mode);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Each observed mode change takes the oldest expected mode
    always @(negedge clk) begin
        if (mode === PMC_WAKE) wake_cnt++;
        if (rstn && mode !== last_mode) begin
            last_mode = mode;
            chk("mode", (q.size() > 0) ? q.pop_front() : 32'hF, mode);
        end
    end

    initial begin
        #100us;
        fail_count++;
        give_verdict();
    end

    //****************************************
    // Scenarios
    //****************************************
    initial begin
        repeat (16) @(negedge clk);
        chk("core_rst_n", 0, core_domain_reset_n);
        chk("power", 32'h1FE, power);
        rstn = 1;
        @(negedge clk);
        chk("core_rst_n", 1, core_domain_reset_n);
        chk("stby_flag", 0, standby_flag);
        for (i = 0; i < 3; i++) begin
            pending_irq_as_event = (i == 2);
            q.push_back(PMC_SLEEP);
            q.push_back(PMC_RUN);
            pmc_core_model_inst.pulse((i == 0) ? WFI : WFE);
            @(negedge clk);
            chk("cpu_clk", 0, power.cpu_clock);
            chk("dom_clk", 1, power.run_domain_clocks);
            if (i == 1) begin
                pmc_core_model_inst.pulse(IRQ);
                chk("mode_hold", PMC_SLEEP, mode);
            end
            pmc_core_model_inst.pulse((i == 1) ? EVT : IRQ);
            wait_mode(PMC_RUN);
        end
        pending_irq_as_event = 0;
        sleep_after_handler_exit = 1;
        pmc_core_model_inst.pulse(WFI);
        q.push_back(PMC_SLEEP);
        q.push_back(PMC_RUN);
        pmc_core_model_inst.pulse(HRL);
        pmc_core_model_inst.pulse(IRQ);
        wait_mode(PMC_RUN);
        sleep_after_handler_exit = 0;
        flash_run_powerdown = 1;
        repeat (2) @(negedge clk);
        chk("flash", 0, power.flash_power);
        flash_run_powerdown = 0;
        q.push_back(PMC_RUN1);
        low_power_regulator_enable = 1;
        wait_mode(PMC_RUN1);
        @(negedge clk);
        chk("nreg", 0, power.normal_core_regulator);
        chk("lpreg", 1, power.low_power_core_regulator);
        chk("slow", 1, power.sysclk_slow);
        q.push_back(PMC_SLEEP1);
        q.push_back(PMC_RUN1);
        pmc_core_model_inst.pulse(WFI);
        @(negedge clk);
        chk("nreg", 0, power.normal_core_regulator);
        pmc_core_model_inst.pulse(IRQ);
        wait_mode(PMC_RUN1);
        q.push_back(PMC_WAKE);
        q.push_back(PMC_RUN);
        wake_cnt = 0;
        low_power_regulator_enable = 0;
        wait_mode(PMC_RUN);
        chk("wake_cyc", `PMC_NREG_CYC + `PMC_FLASH_CYC, wake_cnt);
        core_deep_sleep_select = 1;
        flash_deepsleep_powerdown = 1;
        for (i = 0; i < 3; i++) begin
            low_power_mode_select = (i == 1) ? 2'h1 : 2'h0;
            ext_pending = 1;
            fork
                pmc_core_model_inst.pulse(WFI);
                begin
                    @(negedge clk);
                    #1;
                    chk("skipped", 1, entry_skipped);
                end
            join
            ext_pending = 0;
            q.push_back((i == 1) ? PMC_DEEP1 : PMC_DEEP);
            q.push_back(PMC_WAKE);
            q.push_back(PMC_RUN);
            pmc_core_model_inst.pulse((i == 2) ? WFE : WFI);
            @(negedge clk);
            chk("dom_clk", 0, power.run_domain_clocks);
            chk("fast_osc", 0, power.fast_internal_oscillator);
            chk("crystal", 0, power.high_speed_crystal);
            chk("flash", 0, power.flash_power);
            chk("dom_pwr", 1, power.run_domain_power);
            chk("nreg", i != 1, power.normal_core_regulator);
            pmc_core_model_inst.pulse(IRQ);
            chk("mode_hold", (i == 1) ? PMC_DEEP1 : PMC_DEEP, mode);
            wake_cnt = 0;
            pmc_core_model_inst.pulse((i == 2) ? XEVT : XIRQ);
            wait_mode(PMC_RUN);
            @(negedge clk);
            chk("wake_cyc", `PMC_OSC_CYC + `PMC_FLASH_CYC + ((i == 1) ? `PMC_NREG_CYC : 0),
                wake_cnt);
            chk("slow", 0, power.sysclk_slow);
            chk("fast_osc", 1, power.fast_internal_oscillator);
        end
        low_power_mode_select = 2'h2;
        pmc_core_model_inst.pulse(WFI);
        low_power_mode_select = 2'h3;
        wakeup_flag = 1;
        pmc_core_model_inst.pulse(WFI);
        repeat (3) @(negedge clk);
        wakeup_flag = 0;
        p = $random(seed) & 3;
        wakeup_pin_enable = 4'h1 << p;
        for (i = 0; i < 5; i++) begin
            src = (i < 4) ? (8'h80 >> i) : (8'h01 << p);
            q.push_back(PMC_STBY);
            q.push_back(PMC_WAKE);
            q.push_back(PMC_RUN);
            pmc_core_model_inst.pulse(WFI);
            @(negedge clk);
            chk("dom_pwr", 0, power.run_domain_power);
            chk("nreg", 0, power.normal_core_regulator);
            chk("core_rst_n", 0, core_domain_reset_n);
            wake_cnt = 0;
            if (i == 4) begin
                pmc_core_model_inst.pulse({8'h01 << ((p + 1) & 3), 7'h00});
                chk("mode_hold", PMC_STBY, mode);
            end
            pmc_core_model_inst.pulse({src, 7'h00});
            wait_mode(PMC_RUN);
            @(negedge clk);
            chk("stby_flag", 1, standby_flag);
            chk("wake_cyc", `PMC_OSC_CYC + `PMC_NREG_CYC + `PMC_FLASH_CYC, wake_cnt);
            chk("core_rst_n", 1, core_domain_reset_n);
            chk("boot", 0, boot_address);
            chk("dom_pwr", 1, power.run_domain_power);
        end
        standby_flag_clear = 1;
        @(negedge clk);
        standby_flag_clear = 0;
        @(negedge clk);
        chk("stby_flag", 0, standby_flag);
        chk("queue", 0, q.size());
        give_verdict();
    end
endmodule
